// File: design/ecsf_deserializer.sv
/*
  Deserializer end: hunts for the fixed clock-bit edge, locks, unpacks and
  decodes each frame, and drives the parallel bus with staggered banks and
  optional period spreading. Holds the controller registers and interrupt.
  Assumes the serial bit arrives on clk from the serializer; eq_pin is async.
*/
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
// Functional notes
// RL1 - each 28-bit frame: 24 payload, 2 clock, 2 control
// RL2 - clock bits fixed high and low
// RL3 - low and high clock bits adjacent, fixed edge
// RL4 - bit rate is 28 times pixel rate
// RL5 - 18-bit mode: colour, three syncs, three spare
// RL6 - payload balanced and scrambled, receiver undoes it
// RL7 - control bits carry coding and frame mode
// RL8 - 24-bit mode carries sync state in stream
// RL9 - lock from stream only, no reference
// RL10 - lock status output
// RL11 - relock after hot plug without training
// RL12 - pre-emphasis boost only after a transition
// RL13 - de-emphasis lowers swing, programmable level
// RL14 - swing select low standard, high increased
// RL15 - equalization from pin or register
// RL16 - outputs switch in staggered banks
// RL17 - spread mode rotates bank order each frame
// RL18 - spread spectrum varies output period
// RL19 - lose lock on missing edge, regain consistently
module ecsf_deserializer
  import ecsf_pkg::*;
#(
  parameter bit SCRAMBLE = 1'b1
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  ecsf_link_if.des                     link,
  input  wire logic [EQ_W-1:0]         eq_pin,
  input  wire logic [3:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  output logic                         irq,
  output logic                         lock,
  output logic      [PAYLOAD_BITS-1:0] rgb,
  output logic                         horizontal_sync,
  output logic                         vertical_sync,
  output logic                         pixel_data_valid,
  output logic      [GP_W-1:0]         gp,
  output logic                         pix_stb,
  output logic      [EQ_W-1:0]         eq_setting
);
  typedef struct packed {
    logic [FRAME_BITS-1:0]   sh;
    logic [4:0]              pos;
    logic [2:0]              good;
    logic [1:0]              bad;
    logic                    locked;
    logic [1:0]              frm_cnt;
    logic [PAYLOAD_BITS-1:0] dec_rgb;
    logic                    dec_hsync;
    logic                    dec_vsync;
    logic                    dec_valid;
    logic [GP_W-1:0]         dec_gp;
    logic [2:0]              ssc_ph;
    logic [1:0]              dly;
    logic [1:0]              stg;
    logic                    busy;
    logic [PAYLOAD_BITS-1:0] rgb;
    logic                    hsync;
    logic                    vsync;
    logic                    dvalid;
    logic [GP_W-1:0]         gp;
    logic                    pix_stb;
    logic [EQ_W-1:0]         eq_s1;
    logic [EQ_W-1:0]         eq_s2;
    logic [EQ_W-1:0]         eq_s3;
    logic [EQ_W-1:0]         eq_pv;
    logic [EQ_W-1:0]         eq;
    logic [CTRL_W-1:0]       ctrl;
    logic [IRQ_W-1:0]        stat;
    logic [IRQ_W-1:0]        mask;
    logic [31:0]             rdata;
    logic                    irq;
  } ecsf_rx_state_t;

  ecsf_rx_state_t          s;
  ecsf_rx_state_t          n;
  logic [FRAME_BITS-1:0]   full;
  logic [FRAME_BITS-1:0]   f;
  logic [PAYLOAD_BITS-1:0] d;
  logic                    hit;
  logic                    frame_done;
  logic [IRQ_W-1:0]        ev;
  logic [1:0]              rot;
  logic [STAG_BANKS-1:0]   bank_upd;

  // spread mode walks the start bank with the frame count
  assign rot = s.ctrl[CTRL_SPREAD] ? s.frm_cnt : 2'h0; // [RL17]

  for (genvar k = 0; k < STAG_BANKS; k++) begin : g_bank
    assign bank_upd[k] = ~s.ctrl[CTRL_STAG] | (2'(k) == 2'(s.stg + rot)); // [RL16]
  end

  always_comb begin
    n          = s;
    f          = '0;
    d          = '0;
    ev         = '0;
    frame_done = 1'b0;
    n.pix_stb  = 1'b0;
    full       = {s.sh[FRAME_BITS-2:0], link.serial_bit};
    n.sh       = full;
    // newest bit sits at full[0], so wire index i sits at full[27-i]
    for (int i = 0; i < FRAME_BITS; i++) begin
      f[i] = full[FRAME_BITS-1-i]; // [RL1]
    end
    hit = (f[POS_CLK_LO] == CLK_LO_VAL) && (f[POS_CLK_HI] == CLK_HI_VAL); // [RL2] [RL3]

    // framing: no reference clock, no training, the fixed edge is enough
    if (s.pos == LAST_POS) begin
      n.pos = '0;
      if (hit) begin
        n.bad = '0;
        if (s.locked) begin
          frame_done = 1'b1;
        end else if (s.good == LOCK_GOOD - 3'h1) begin
          n.locked       = 1'b1; // [RL9] [RL11] [RL19]
          n.good         = '0;
          ev[IRQ_GAIN]   = 1'b1;
        end else begin
          n.good = s.good + 3'h1; // [RL19]
        end
      end else begin
        n.good = '0;
        if (s.locked) begin
          ev[IRQ_ERR] = 1'b1;
          if (s.bad == LOCK_BAD - 2'h1) begin
            n.locked     = 1'b0; // [RL19]
            n.bad        = '0;
            ev[IRQ_LOSS] = 1'b1;
          end else begin
            n.bad = s.bad + 2'h1;
          end
        end else begin
          // slip one bit: test the next alignment on the next clock
          n.pos = LAST_POS; // [RL9] [RL11]
        end
      end
    end else begin
      n.pos = s.pos + 5'h01; // [RL4]
    end

    // decode: undo balance inversion, then the scrambler
    if (frame_done) begin
      d = f[PAYLOAD_BITS-1:0] ^ {PAYLOAD_BITS{f[POS_A]}}; // [RL6] [RL7]
      if (SCRAMBLE) begin
        for (int i = 1; i < PAYLOAD_BITS; i++) begin
          d[i] = f[i] ^ f[POS_A] ^ f[i-1] ^ f[POS_A]; // [RL6]
        end
      end
      if (s.ctrl[CTRL_C24]) begin
        if (f[POS_B]) begin
          // sync held between blanking frames, colour blanked
          n.dec_valid = 1'b0; // [RL8]
          n.dec_hsync = d[BLANK_HSYNC];
          n.dec_vsync = d[BLANK_VSYNC];
          n.dec_gp    = d[SYNC_GP_LSB +: GP_W];
          n.dec_rgb   = '0;
        end else begin
          n.dec_valid = 1'b1; // [RL7] [RL8]
          n.dec_rgb   = d;
        end
      end else begin
        n.dec_rgb = {{(PAYLOAD_BITS-RGB18_W){1'b0}}, d[RGB18_W-1:0]}; // [RL5]
        n.dec_hsync = d[HSYNC_BIT];
        n.dec_vsync = d[VSYNC_BIT];
        n.dec_valid = d[DVALID_BIT];
        n.dec_gp  = d[GP_LSB +: GP_W];
      end
      n.frm_cnt = s.frm_cnt + 2'h1;
      n.ssc_ph  = s.ssc_ph + 3'h1;
      // triangle offset 0,1,2,3,3,2,1,0 stretches and shrinks the period
      n.dly  = s.ctrl[CTRL_SSC] ? (s.ssc_ph[2] ? ~s.ssc_ph[1:0] : s.ssc_ph[1:0]) : 2'h0; // [RL18]
      n.stg  = '0;
      n.busy = 1'b1;
    end

    // output stage: optional delay, then one bank per clock when staggered, else all banks in one clock
    if (s.busy) begin
      if (s.dly != 2'h0) begin
        n.dly = s.dly - 2'h1; // [RL18]
      end else begin
        for (int k = 0; k < STAG_BANKS; k++) begin
          if (bank_upd[k]) begin
            n.rgb[k*BANK_W +: BANK_W] = s.dec_rgb[k*BANK_W +: BANK_W]; // [RL16] [RL17]
          end
        end
        if (s.stg == 2'h0) begin
          n.hsync  = s.dec_hsync;
          n.vsync  = s.dec_vsync;
          n.dvalid = s.dec_valid;
          n.gp     = s.dec_gp;
        end
        if (!s.ctrl[CTRL_STAG] || s.stg == 2'(STAG_BANKS - 1)) begin
          n.busy    = 1'b0;
          n.pix_stb = 1'b1;
        end else begin
          n.stg = s.stg + 2'h1; // [RL16]
        end
      end
    end

    // pin equalization value: three stages, accepted when two agree
    n.eq_s1 = eq_pin;
    n.eq_s2 = s.eq_s1;
    n.eq_s3 = s.eq_s2;
    if (s.eq_s2 == s.eq_s3) begin
      n.eq_pv = s.eq_s3;
    end
    n.eq = s.ctrl[CTRL_EQSRC] ? s.ctrl[CTRL_EQ_LSB +: EQ_W] : s.eq_pv; // [RL15]

    // registers; a hardware event in the clearing cycle stays set
    n.rdata = '0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL:     n.ctrl = reg_wdata[CTRL_W-1:0];
        ADDR_IRQ_STAT: n.stat = s.stat & ~reg_wdata[IRQ_W-1:0];
        ADDR_IRQ_MASK: n.mask = reg_wdata[IRQ_W-1:0];
        default:       n.ctrl = s.ctrl;
      endcase
    end
    n.stat = n.stat | ev;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL:     n.rdata = {{(32-CTRL_W){1'b0}}, s.ctrl};
        ADDR_STATUS:   n.rdata = {24'h000000, s.eq, 2'h0, s.busy, s.locked}; // [RL10]
        ADDR_IRQ_STAT: n.rdata = {{(32-IRQ_W){1'b0}}, s.stat};
        ADDR_IRQ_MASK: n.rdata = {{(32-IRQ_W){1'b0}}, s.mask};
        default:       n.rdata = 32'h00000000;
      endcase
    end
    n.irq = |(n.stat & n.mask);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s      <= '0;
      s.ctrl <= CTRL_RST;
      s.stat <= IRQ_RST;
      s.mask <= IRQ_RST;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata  = s.rdata;
  assign irq        = s.irq;
  assign lock       = s.locked; // [RL10]
  assign rgb        = s.rgb;
  assign horizontal_sync  = s.hsync;
  assign vertical_sync    = s.vsync;
  assign pixel_data_valid = s.dvalid;
  assign gp         = s.gp;
  assign pix_stb    = s.pix_stb;
  assign eq_setting = s.eq;
endmodule

// File: design/ecsf_pkg.sv
/*
  Shared constants for the embedded-clock serializer/deserializer pair:
  frame layout, payload packing, lock thresholds and the controller register map.
  Assumes both ends compile against the same copy of this package.
*/
package ecsf_pkg;
  // frame layout, index = order on the wire (index 0 goes first)
  localparam int         FRAME_BITS   = 28;
  localparam int         PAYLOAD_BITS = 24;
  localparam int         POS_A        = 24;
  localparam int         POS_B        = 25;
  localparam int         POS_CLK_LO   = 26;
  localparam int         POS_CLK_HI   = 27;
  localparam logic [4:0] LAST_POS     = 5'h1B;
  localparam logic       CLK_LO_VAL   = 1'b0;
  localparam logic       CLK_HI_VAL   = 1'b1;
  localparam logic [4:0] HALF_ONES    = 5'h0C;

  // 18-bit colour packing
  localparam int RGB18_W    = 18;
  localparam int HSYNC_BIT  = 18;
  localparam int VSYNC_BIT  = 19;
  localparam int DVALID_BIT = 20;
  localparam int GP_LSB     = 21;
  localparam int GP_W       = 3;

  // 24-bit colour blanking frame packing
  localparam int BLANK_HSYNC = 0;
  localparam int BLANK_VSYNC = 1;
  localparam int SYNC_GP_LSB = 2;

  // serial bit time equals one clock period
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_NS        = 10;
  localparam int BIT_CYCLES    = (BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // lock acquisition
  localparam logic [2:0] LOCK_GOOD = 3'h4;
  localparam logic [1:0] LOCK_BAD  = 2'h2;

  // staggered output banks
  localparam int STAG_BANKS = 4;
  localparam int BANK_W     = 6;

  // controller registers
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
  localparam int         CTRL_STAG     = 0;
  localparam int         CTRL_SPREAD   = 1;
  localparam int         CTRL_SSC      = 2;
  localparam int         CTRL_EQSRC    = 3;
  localparam int         CTRL_EQ_LSB   = 4;
  localparam int         CTRL_C24      = 8;
  localparam int         CTRL_W        = 9;
  localparam logic [8:0] CTRL_RST      = 9'h000;
  localparam int         EQ_W          = 4;
  localparam int         IRQ_GAIN      = 0;
  localparam int         IRQ_LOSS      = 1;
  localparam int         IRQ_ERR       = 2;
  localparam int         IRQ_W         = 3;
  localparam logic [2:0] IRQ_RST       = 3'h0;
endpackage

// File: design/ecsf_link_if.sv
/*
  Serial link between the serializer and the deserializer.
  Assumes both ends share clk; one serial bit per clock.
*/
`timescale 1ns/1ps
interface ecsf_link_if;
  logic       serial_bit;
  logic       tx_boost;
  logic [1:0] tx_deemph;
  logic       tx_swing_high;

  modport serializer (output serial_bit, output tx_boost, output tx_deemph, output tx_swing_high);
  modport des (input serial_bit, input tx_boost, input tx_deemph, input tx_swing_high);
endinterface

// File: design/ecsf_serializer.sv
/*
  Serializer end: packs one pixel per 28-clock frame, scrambles, DC balances,
  appends control and clock bits, and shifts the frame out one bit per clock.
  Assumes pixel inputs come from logic on clk and are held while pix_stb is low.
*/
`timescale 1ns/1ps
module ecsf_serializer
  import ecsf_pkg::*;
#(
  parameter bit SCRAMBLE = 1'b1
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  ecsf_link_if.serializer              link,
  input  wire logic                    color24,
  input  wire logic [PAYLOAD_BITS-1:0] rgb,
  input  wire logic                    horizontal_sync,
  input  wire logic                    vertical_sync,
  input  wire logic                    pixel_data_valid,
  input  wire logic [GP_W-1:0]         gp,
  input  wire logic                    pre_emph_en,
  input  wire logic                    deemph_en,
  input  wire logic [1:0]              deemph_set,
  input  wire logic                    swing_sel,
  output logic                         pix_stb
);
  typedef struct packed {
    logic [4:0]            pos;
    logic [FRAME_BITS-1:0] frame;
    logic signed [5:0]     disp;
    logic                  out_bit;
    logic                  boost;
    logic [1:0]            deemph;
    logic                  swing;
    logic                  pix_stb;
  } ecsf_tx_state_t;

  ecsf_tx_state_t            s;
  ecsf_tx_state_t            n;
  logic [PAYLOAD_BITS-1:0]   p;
  logic [PAYLOAD_BITS-1:0]   sc;
  logic [4:0]                ones;
  logic                      inv;
  logic                      b;
  logic signed [5:0]         delta;

  always_comb begin
    n     = s;
    p     = '0;
    sc    = '0;
    ones  = '0;
    inv   = 1'b0;
    b     = 1'b0;
    delta = '0;
    n.pix_stb = 1'b0;
    n.out_bit = s.frame[s.pos];
    // boost only on a changing bit; a repeated bit needs no extra current
    n.boost   = pre_emph_en & (s.frame[s.pos] != s.out_bit); // [RL12]
    n.deemph  = deemph_en ? deemph_set : 2'h0; // [RL13]
    n.swing   = swing_sel; // [RL14]
    if (s.pos == LAST_POS) begin
      // pixel rate is the bit rate divided by 28
      n.pos     = '0; // [RL4]
      n.pix_stb = 1'b1;
      if (color24) begin
        if (pixel_data_valid) begin
          p = rgb;
        end else begin
          // blanking frames carry the sync state instead of colour
          p[BLANK_HSYNC]         = horizontal_sync; // [RL8]
          p[BLANK_VSYNC]         = vertical_sync;
          p[SYNC_GP_LSB +: GP_W] = gp;
          b                      = 1'b1; // [RL7]
        end
      end else begin
        p[RGB18_W-1:0]    = rgb[RGB18_W-1:0]; // [RL5]
        p[HSYNC_BIT]      = horizontal_sync;
        p[VSYNC_BIT]      = vertical_sync;
        p[DVALID_BIT]     = pixel_data_valid;
        p[GP_LSB +: GP_W] = gp;
      end
      sc = p;
      if (SCRAMBLE) begin
        for (int i = 1; i < PAYLOAD_BITS; i++) begin
          sc[i] = p[i] ^ sc[i-1]; // [RL6]
        end
      end
      for (int i = 0; i < PAYLOAD_BITS; i++) begin
        ones = ones + 5'(sc[i]);
      end
      // invert when the word would push running disparity further out
      inv    = (ones != HALF_ONES) && ((ones > HALF_ONES) == (s.disp > 0)); // [RL6]
      delta  = $signed({1'b0, ones}) - $signed({1'b0, HALF_ONES});
      n.disp = inv ? s.disp - delta : s.disp + delta;
      n.frame = {CLK_HI_VAL, CLK_LO_VAL, b, inv, sc ^ {PAYLOAD_BITS{inv}}}; // [RL1] [RL2] [RL3] [RL7]
    end else begin
      n.pos = s.pos + 5'h01; // [RL4]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign link.serial_bit    = s.out_bit;
  assign link.tx_boost      = s.boost;
  assign link.tx_deemph     = s.deemph;
  assign link.tx_swing_high = s.swing;
  assign pix_stb            = s.pix_stb;
endmodule

// File: sim/ecsf_monitor.sv
/*
  Link wire checker: clock bit pair, strobe period, driver shaping.
  Assumes one serial bit per clk and pix_stb from the serializer.
*/
`timescale 1ns/1ps
module ecsf_monitor
  import ecsf_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       serial_bit,
  input wire logic       tx_boost,
  input wire logic [1:0] tx_deemph,
  input wire logic       tx_swing_high,
  input wire logic       pix_stb,
  input wire logic       pre_emph_en,
  input wire logic       deemph_en,
  input wire logic [1:0] deemph_set,
  input wire logic       swing_sel
);
  logic       armed_r;
  logic [1:0] run_r;
  // the frame sent right after reset has no clock pair, so skip the first strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
      run_r   <= 2'h0;
    end else begin
      armed_r <= armed_r | pix_stb;
      run_r   <= (run_r == 2'h3) ? run_r : run_r + 2'h1;
    end
  end
  wire logic run_ok = (run_r == 2'h3);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence clk_pair_s;
    ##27 (serial_bit == CLK_LO_VAL) ##1 (serial_bit == CLK_HI_VAL);
  endsequence
  sequence stb_gap_s;
    !pix_stb [*8];
  endsequence

  a_clock_pair_fixed: assert property (armed_r && pix_stb |-> clk_pair_s)
    else $error("clock bit pair wrong");
  a_frame_period: assert property (pix_stb |-> ##28 pix_stb)
    else $error("frame period not 28 bits");
  a_stb_spacing: assert property (pix_stb |=> stb_gap_s)
    else $error("pixel strobe too soon");
  a_boost_on_edge: assert property (run_ok && pre_emph_en && $stable(pre_emph_en)
    && $changed(serial_bit) |-> tx_boost)
    else $error("boost missing after transition");
  a_boost_same_bit: assert property (run_ok && $stable(serial_bit) |-> !tx_boost)
    else $error("boost on repeated bit");
  a_boost_disabled: assert property (run_ok && !pre_emph_en && $stable(pre_emph_en)
    |-> !tx_boost)
    else $error("boost while disabled");
  a_deemph_level: assert property (run_ok && $stable(deemph_en) && $stable(deemph_set)
    |-> tx_deemph == (deemph_en ? deemph_set : 2'h0))
    else $error("de-emphasis level wrong");
  a_swing_copy: assert property (run_ok |-> tx_swing_high == $past(swing_sel))
    else $error("swing select not followed");
endmodule

// File: sim/ecsf_tb_top.sv
/*
  Bench for the serializer and deserializer joined by the link interface.
  Assumes the package constants and a 100 MHz clk; no partner model.
*/
`timescale 1ns/1ps
module ecsf_tb_top
  import ecsf_pkg::*;
;
  logic                    clk, rst_n, tx_rst_n, color24, pre_en, dmp_en, swing;
  logic                    horizontal_sync_i, vertical_sync_i, pixel_data_valid_i;
  logic                    horizontal_sync_o, vertical_sync_o, pixel_data_valid_o;
  logic                    reg_wr, reg_rd, tx_stb, irq, lock, des_stb;
  logic [PAYLOAD_BITS-1:0] rgb_i, rgb;
  logic [GP_W-1:0]         gp_i, gp;
  logic [1:0]              dmp_set;
  logic [EQ_W-1:0]         eq_pin, eq_set;
  logic [3:0]              reg_addr;
  logic [31:0]             reg_wdata, reg_rdata, v;
  int                      err_total, cmp_count;
  int                      cyc = 0;
  logic [31:0]             ctl [4] = '{32'h0, 32'h1, 32'h3, 32'h7};
  logic [29:0]             pat [4] = '{30'h3FFFFFFF, 30'h00A5C3AD, 30'h0015555A, 30'h002AAAA5};

  ecsf_link_if link ();
  ecsf_serializer ecsf_serializer_i (.clk(clk), .rst_n(tx_rst_n), .link(link), .color24(color24),
    .rgb(rgb_i), .horizontal_sync(horizontal_sync_i), .vertical_sync(vertical_sync_i),
    .pixel_data_valid(pixel_data_valid_i), .gp(gp_i), .pre_emph_en(pre_en),
    .deemph_en(dmp_en), .deemph_set(dmp_set), .swing_sel(swing), .pix_stb(tx_stb));
  ecsf_deserializer ecsf_deserializer_i (.clk(clk), .rst_n(rst_n), .link(link), .eq_pin(eq_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .lock(lock), .rgb(rgb),
    .horizontal_sync(horizontal_sync_o), .vertical_sync(vertical_sync_o),
    .pixel_data_valid(pixel_data_valid_o), .gp(gp), .pix_stb(des_stb), .eq_setting(eq_set));
  ecsf_monitor ecsf_monitor_i (.clk(clk), .rst_n(tx_rst_n), .serial_bit(link.serial_bit),
    .tx_boost(link.tx_boost), .tx_deemph(link.tx_deemph), .tx_swing_high(link.tx_swing_high),
    .pix_stb(tx_stb), .pre_emph_en(pre_en), .deemph_en(dmp_en), .deemph_set(dmp_set),
    .swing_sel(swing));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the whole sequence needs under two thousand cycles; a stalled lock hunt ends here
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata & m, e);
  endtask

  task automatic pix(input logic [29:0] w);
    @(posedge clk);
    {rgb_i, horizontal_sync_i, vertical_sync_i, pixel_data_valid_i, gp_i} <= w;
  endtask

  // outputs are settled from the cycle whose edge raised pix_stb
  task automatic wait_pix(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k++;
      end while (des_stb !== 1'b1 && k < 200);
    end
  endtask

  task automatic wait_lock(input logic want);
    for (int k = 0; k < 600 && lock !== want; k++) @(posedge clk);
    #1;
  endtask

  task automatic chk_out(input logic [29:0] e, input logic [29:0] m);
    check({rgb, horizontal_sync_o, vertical_sync_o, pixel_data_valid_o, gp} & m, e & m);
  endtask

  initial begin
    {rst_n, tx_rst_n, color24, reg_wr, reg_rd, dmp_en, swing} = 7'h03;
    {rgb_i, horizontal_sync_i, vertical_sync_i, pixel_data_valid_i, gp_i} = '0;
    {reg_addr, reg_wdata} = '0;
    {pre_en, dmp_set, eq_pin} = 7'h56;
    err_total = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst_n    <= 1'b1;
    tx_rst_n <= 1'b1;
    rd(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    rd(ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
    wr(ADDR_CTRL, 32'h1FF);
    rd(ADDR_CTRL, 32'hFFFFFFFF, 32'h1FF);
    wr(4'h2, 32'hFF);
    rd(4'h2, 32'hFFFFFFFF, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h7);
    $display("test registers done");
    wait_lock(1'b1);
    check(lock, 1'b1);
    rd(ADDR_STATUS, 32'hF1, 32'h61);
    rd(ADDR_IRQ_STAT, 32'h7, 32'h1);
    check(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h1);
    rd(ADDR_IRQ_STAT, 32'h7, 32'h0);
    check(irq, 1'b0);
    $display("test lock done");
    // all-ones payload scrambles to a balanced word, so no inversion; later modes add stagger, then spread, then period spreading
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, ctl[i]);
      pix(pat[i]);
      wait_pix(5);
      chk_out(pat[i], 30'h00FFFFFF);
    end
    $display("test 18-bit modes done");
    wr(ADDR_CTRL, 32'h100);
    @(posedge clk);
    {color24, pre_en, dmp_en, swing} <= 4'h8;
    pix({24'h0, 3'b110, 3'h3});
    wait_pix(5);
    chk_out({24'h0, 3'b110, 3'h3}, 30'h0000003F);
    pix({24'hC35A96, 3'b001, 3'h3});
    wait_pix(5);
    chk_out({24'hC35A96, 3'b111, 3'h0}, 30'h3FFFFFF8);
    $display("test 24-bit done");
    wr(ADDR_IRQ_STAT, 32'h7);
    @(posedge clk);
    tx_rst_n <= 1'b0;
    wait_lock(1'b0);
    check(lock, 1'b0);
    rd(ADDR_IRQ_STAT, 32'h6, 32'h6);
    check(irq, 1'b1);
    @(posedge clk);
    tx_rst_n <= 1'b1;
    wait_lock(1'b1);
    check(lock, 1'b1);
    wait_pix(5);
    chk_out({24'hC35A96, 3'b111, 3'h0}, 30'h3FFFFFF8);
    $display("test hot plug done");
    wr(ADDR_CTRL, 32'h198);
    repeat (3) @(posedge clk);
    #1;
    check(eq_set, 4'h9);
    rd(ADDR_STATUS, 32'hF0, 32'h90);
    @(posedge clk);
    eq_pin <= 4'hA;
    wr(ADDR_CTRL, 32'h100);
    repeat (8) @(posedge clk);
    #1;
    check(eq_set, 4'hA);
    $display("test equalization done");
    results();
  end
endmodule
